/* File: can_msg_store_pkg.sv */
// Contract
// - three transmit buffers, each 13 message bytes, 8-bit priority, two stamp bytes
// - a successful send sets that buffer's empty flag again
// - a set empty flag raises the transmit interrupt unless masked
// - among pending buffers the smallest priority value is sent first
// - prioritisation reruns at every arbitration, retries included
// - software requests abort; a message already on the bus is never aborted
// - granted abort sets acknowledge and empty; acknowledge reads 1 aborted, 0 sent
// - received messages go to a five-entry fifo; only the foreground is mapped
// - each receive buffer holds 15 bytes: control, identifier, data, stamp
// - receive-full is set only while the foreground holds an accepted message
// - frame is written to background; valid accepted frame is queued and signalled
// - rejected or corrupted frames are not queued; next frame overwrites background
// - a new frame can be taken right after the interframe space
// - own frames outside loopback are captured but not queued, signalled or acked
// - in loopback own frames are treated like any received frame
// - after lost arbitration the winning frame is received normally
// - accepted frame with fifo full is dropped and flags overrun
// - while full, transmission goes on and frames are dropped until space frees
// - equal lowest priorities resolve to the smaller buffer index
// - priority is writable only while the buffer is empty and selected
package can_msg_store_pkg;

  localparam int TX_BUFS = 3;
  localparam int TX_MSG_BYTES = 13;
  localparam int TX_WIN_BYTES = 16;
  localparam int RX_MSG_BYTES = 15;
  localparam int RX_DEPTH_DEF = 5;
  localparam logic [3:0] TX_LOCAL_PRIORITY_FIELD_BYTE = 4'hd;
  localparam logic [3:0] TX_TS_HI_BYTE = 4'he;
  localparam logic [3:0] TX_TS_LO_BYTE = 4'hf;
  localparam logic [3:0] RX_TS_HI_BYTE = 4'hd;
  localparam logic [3:0] RX_TS_LO_BYTE = 4'he;

  // register byte addresses
  localparam logic [7:0] ADDR_RX_FLAG = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_TX_FLAG = 8'h08;
  localparam logic [7:0] ADDR_ABORT_REQ = 8'h0c;
  localparam logic [7:0] ADDR_ABORT_ACK = 8'h10;
  localparam logic [7:0] ADDR_TX_SEL = 8'h14;
  // windows decoded on address bits 7:6, byte index on bits 5:2
  localparam logic [1:0] WIN_RX = 2'h1;
  localparam logic [1:0] WIN_TX = 2'h2;

  // field positions
  localparam int RXF_BIT = 0;
  localparam int OVR_BIT = 1;
  localparam int CTRL_LOOP_BIT = 0;
  localparam int CTRL_RXIE_BIT = 1;
  localparam int CTRL_OVRIE_BIT = 2;
  localparam int CTRL_TXIE_LSB = 4;

  localparam logic [2:0] TX_EMPTY_RST = 3'h7;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage

/* File: can_msg_store.sv */
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module can_msg_store
  import can_msg_store_pkg::*;
#(
  parameter int RX_DEPTH = RX_DEPTH_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // protocol engine, transmit side
  input wire logic arb_req,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic tx_error,
  input wire logic arb_lost,
  output logic tx_pick_valid,
  output logic [1:0] tx_pick_idx,
  output logic [TX_MSG_BYTES*8-1:0] tx_frame,
  // protocol engine, receive side
  input wire logic rx_byte_we,
  input wire logic [3:0] rx_byte_idx,
  input wire logic [7:0] rx_byte_data,
  input wire logic rx_frame_done,
  input wire logic rx_frame_ok,
  input wire logic rx_filter_hit,
  input wire logic rx_own_frame,
  output logic rx_space,
  output logic ack_own_frames,
  // bit-clock time stamp
  input wire logic [15:0] timestamp,
  // masked event levels toward the interrupt logic
  output logic tx_irq,
  output logic rx_irq,
  output logic overrun_irq
);

  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(RX_DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(RX_DEPTH);

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [TX_BUFS-1:0] empty;
    logic [TX_BUFS-1:0] abort_req;
    logic [TX_BUFS-1:0] abort_ack;
    logic [TX_BUFS-1:0] busy;
    logic [TX_BUFS-1:0] sel;
    // three buffers of message bytes, priority and stamp
    logic [TX_BUFS-1:0][TX_WIN_BYTES-1:0][7:0] txbuf;
    logic loopback;
    logic rx_ie;
    logic ovr_ie;
    logic [TX_BUFS-1:0] tx_ie;
    logic [RX_DEPTH-1:0][RX_MSG_BYTES-1:0][7:0] rxbuf;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic ovr;
    logic pick_valid;
    logic [1:0] pick_idx;
    logic [TX_MSG_BYTES-1:0][7:0] frame;
  } state_t;

  state_t s;
  state_t next_s;
  logic [1:0] sel_idx;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PTR_LAST) ? '0 : PW'(p + 1'b1);
  endfunction

  always_comb begin
    sel_idx = 2'h0;
    for (int i = TX_BUFS - 1; i >= 0; i--) begin
      if (s.sel[i]) begin
        sel_idx = 2'(i);
      end
    end
  end

  function automatic logic [33:0] read_word(input state_t st, input logic [7:0] a,
                                            input logic [1:0] si);
    logic [31:0] d;
    logic [1:0] r;
    d = '0;
    r = AXI_OKAY;
    if (a == ADDR_RX_FLAG) begin
      d[RXF_BIT] = (st.count != '0);
      d[OVR_BIT] = st.ovr;
    end else if (a == ADDR_CTRL) begin
      d[CTRL_LOOP_BIT] = st.loopback;
      d[CTRL_RXIE_BIT] = st.rx_ie;
      d[CTRL_OVRIE_BIT] = st.ovr_ie;
      d[CTRL_TXIE_LSB +: TX_BUFS] = st.tx_ie;
    end else if (a == ADDR_TX_FLAG) begin
      d[TX_BUFS-1:0] = st.empty;
    end else if (a == ADDR_ABORT_REQ) begin
      d[TX_BUFS-1:0] = st.abort_req;
    end else if (a == ADDR_ABORT_ACK) begin
      d[TX_BUFS-1:0] = st.abort_ack;
    end else if (a == ADDR_TX_SEL) begin
      d[TX_BUFS-1:0] = st.sel;
    end else if (a[7:6] == WIN_RX && a[5:2] < 4'(RX_MSG_BYTES) && a[1:0] == 2'h0) begin
      // only the foreground entry is visible
      d[7:0] = st.rxbuf[st.rd_ptr][a[5:2]];
    end else if (a[7:6] == WIN_TX && a[1:0] == 2'h0) begin
      if (st.sel != '0) begin
        d[7:0] = st.txbuf[si][a[5:2]];
      end
    end else begin
      r = AXI_SLVERR;
    end
    read_word = {r, d};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] wa;
    logic [7:0] wd;
    logic we;
    logic pop;
    logic push;
    logic found;
    logic [7:0] best;
    logic [1:0] besti;
    logic [TX_BUFS-1:0] cand;
    logic [3:0] bi;
    wa = '0;
    wd = '0;
    we = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    found = 1'b0;
    best = '0;
    besti = '0;
    cand = '0;
    bi = '0;
    next_s = s;

    // bus handshakes
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      {next_s.rresp, next_s.rdata} = read_word(s, araddr, sel_idx);
    end
    if (awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end

    // register writes, hardware events below take precedence
    if (next_s.aw_held && next_s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = AXI_OKAY;
      wa = next_s.aw_addr;
      wd = next_s.w_data[7:0];
      we = next_s.w_strb[0];
      if (wa == ADDR_RX_FLAG) begin
        if (we && wd[RXF_BIT] && s.count != '0) begin
          pop = 1'b1;
        end
        if (we && wd[OVR_BIT]) begin
          next_s.ovr = 1'b0;
        end
      end else if (wa == ADDR_CTRL) begin
        if (we) begin
          next_s.loopback = wd[CTRL_LOOP_BIT];
          next_s.rx_ie = wd[CTRL_RXIE_BIT];
          next_s.ovr_ie = wd[CTRL_OVRIE_BIT];
          next_s.tx_ie = wd[CTRL_TXIE_LSB +: TX_BUFS];
        end
      end else if (wa == ADDR_TX_FLAG) begin
        if (we) begin
          next_s.empty = s.empty & ~wd[TX_BUFS-1:0];
          next_s.abort_ack = s.abort_ack & ~(wd[TX_BUFS-1:0] & s.empty);
        end
      end else if (wa == ADDR_ABORT_REQ) begin
        if (we) begin
          next_s.abort_req = s.abort_req | (wd[TX_BUFS-1:0] & ~s.empty);
        end
      end else if (wa == ADDR_TX_SEL) begin
        if (we) begin
          // lowest requested empty buffer is mapped
          next_s.sel = '0;
          for (int i = TX_BUFS - 1; i >= 0; i--) begin
            if (wd[i] && s.empty[i]) begin
              next_s.sel = '0;
              next_s.sel[i] = 1'b1;
            end
          end
        end
      end else if (wa == ADDR_ABORT_ACK) begin
        next_s.bresp = AXI_OKAY;
      end else if (wa[7:6] == WIN_TX && wa[1:0] == 2'h0) begin
        bi = wa[5:2];
        // priority and message writable only while empty and selected
        if (we && s.sel != '0 && s.empty[sel_idx] && bi <= TX_LOCAL_PRIORITY_FIELD_BYTE) begin
          next_s.txbuf[sel_idx][bi] = wd;
        end
      end else if (wa[7:6] == WIN_RX && wa[5:2] < 4'(RX_MSG_BYTES) && wa[1:0] == 2'h0) begin
        next_s.bresp = AXI_OKAY;
      end else begin
        next_s.bresp = AXI_SLVERR;
      end
    end

    // ----------------------------------------------------------------
    // transmit scheduling
    // ----------------------------------------------------------------
    if (tx_start && s.pick_valid && !next_s.empty[s.pick_idx]) begin
      next_s.busy[s.pick_idx] = 1'b1;
    end
    if (tx_done && s.busy[s.pick_idx]) begin
      // sent buffer becomes empty, acknowledge reads 0
      next_s.busy[s.pick_idx] = 1'b0;
      next_s.empty[s.pick_idx] = 1'b1;
      next_s.abort_req[s.pick_idx] = 1'b0;
      next_s.abort_ack[s.pick_idx] = 1'b0;
      next_s.txbuf[s.pick_idx][TX_TS_HI_BYTE] = timestamp[15:8];
      next_s.txbuf[s.pick_idx][TX_TS_LO_BYTE] = timestamp[7:0];
      next_s.pick_valid = 1'b0;
    end
    if (tx_error || arb_lost) begin
      // lost arbitration or error clears busy, the buffer stays pending; the engine turns receiver
      next_s.busy = '0;
      next_s.pick_valid = 1'b0;
    end
    for (int i = 0; i < TX_BUFS; i++) begin
      // never abort while on the bus
      if (s.abort_req[i] && !next_s.empty[i] && !next_s.busy[i]) begin
        next_s.abort_ack[i] = 1'b1;
        next_s.empty[i] = 1'b1;
        next_s.abort_req[i] = 1'b0;
        if (s.pick_idx == 2'(i)) begin
          next_s.pick_valid = 1'b0;
        end
      end
    end
    if (arb_req) begin
      cand = ~next_s.empty;
      for (int i = 0; i < TX_BUFS; i++) begin
        // smallest value wins; strict compare keeps lower index
        if (cand[i] && (!found || s.txbuf[i][TX_LOCAL_PRIORITY_FIELD_BYTE] < best)) begin
          found = 1'b1;
          best = s.txbuf[i][TX_LOCAL_PRIORITY_FIELD_BYTE];
          besti = 2'(i);
        end
      end
      next_s.pick_valid = found;
      next_s.pick_idx = besti;
      for (int b = 0; b < TX_MSG_BYTES; b++) begin
        next_s.frame[b] = s.txbuf[besti][b];
      end
    end

    // ----------------------------------------------------------------
    // receive fifo
    // ----------------------------------------------------------------
    // no background while every entry holds a message
    if (rx_byte_we && s.count != CNT_FULL && rx_byte_idx < 4'(RX_MSG_BYTES)) begin
      // frame lands in the background entry; a dropped frame gets overwritten
      next_s.rxbuf[s.wr_ptr][rx_byte_idx] = rx_byte_data;
    end
    // own frame skipped outside loopback; taken in loopback
    if (rx_frame_done && rx_frame_ok && rx_filter_hit && (!rx_own_frame || s.loopback)) begin
      if (s.count == CNT_FULL) begin
        next_s.ovr = 1'b1;
      end else begin
        next_s.rxbuf[s.wr_ptr][RX_TS_HI_BYTE] = timestamp[15:8];
        next_s.rxbuf[s.wr_ptr][RX_TS_LO_BYTE] = timestamp[7:0];
        push = 1'b1;
      end
    end
    // next background entry ready at once
    if (push) begin
      next_s.wr_ptr = ptr_inc(s.wr_ptr);
    end
    // next oldest entry moves to the foreground
    if (pop) begin
      next_s.rd_ptr = ptr_inc(s.rd_ptr);
    end
    // a queued frame keeps receive-full set even under a clear
    next_s.count = CW'(s.count + CW'(push) - CW'(pop));
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.empty <= TX_EMPTY_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = !s.aw_held && !s.bvalid;
  assign wready = !s.w_held && !s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign tx_pick_valid = s.pick_valid;
  assign tx_pick_idx = s.pick_idx;
  assign tx_frame = s.frame;
  assign rx_space = (s.count != CNT_FULL);
  // engine acks own frames only in loopback
  assign ack_own_frames = s.loopback;
  assign tx_irq = |(s.empty & s.tx_ie);
  assign rx_irq = (s.count != '0) && s.rx_ie;
  assign overrun_irq = s.ovr && s.ovr_ie;

endmodule

/* File: can_msg_store_monitor.sv */
`timescale 1ns/1ps
module can_msg_store_monitor
  import can_msg_store_pkg::*;
#(
  parameter int RX_DEPTH = RX_DEPTH_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic bvalid,
  // transmit engine
  input wire logic arb_req,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic tx_error,
  input wire logic arb_lost,
  input wire logic tx_pick_valid,
  // receive engine
  input wire logic rx_frame_done,
  input wire logic rx_frame_ok,
  input wire logic rx_filter_hit,
  input wire logic rx_own_frame,
  input wire logic rx_space,
  input wire logic ack_own_frames,
  // event levels
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic overrun_irq
);
  // ---------------------------------
  // delayed causes
  // ---------------------------------
  logic acc_d, full_d, ev_d, ev_dd;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {acc_d, full_d, ev_d, ev_dd} <= 4'h0;
    end else begin
      acc_d <= rx_frame_done & rx_frame_ok & rx_filter_hit & (!rx_own_frame | ack_own_frames);
      full_d <= !rx_space;
      ev_d <= tx_done | tx_error | arb_lost;
      ev_dd <= ev_d;
    end
  end
  // ---------------------------------
  // properties
  // ---------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_started;
    tx_pick_valid && tx_start;
  endsequence
  sequence s_sent;
    s_started ##1 ((!tx_error && !arb_lost) throughout (##[0:40] tx_done));
  endsequence
  a_pick_cause: assert property ($rose(tx_pick_valid) |-> $past(arb_req))
    else $error("pick without arbitration");
  a_started_kept: assert property (tx_pick_valid && tx_start && !tx_done && !tx_error
    && !arb_lost && !arb_req |=> tx_pick_valid) else $error("started frame dropped");
  a_sent_drop: assert property (s_sent |=> !tx_pick_valid)
    else $error("sent frame still picked");
  a_tx_irq_cause: assert property ($rose(tx_irq) |-> ev_d || ev_dd || bvalid
    || $past(bvalid) || $past(bvalid, 2)) else $error("tx event without cause");
  a_rx_irq_cause: assert property ($rose(rx_irq) |-> acc_d || bvalid)
    else $error("rx event without accepted frame");
  a_ovr_cause: assert property ($rose(overrun_irq) |-> (acc_d && full_d) || bvalid)
    else $error("overrun without full fifo");
  a_fill_cause: assert property ($fell(rx_space) |-> acc_d)
    else $error("fifo filled without accepted frame");
  a_free_cause: assert property ($rose(rx_space) |-> bvalid)
    else $error("fifo freed without release");
  a_loop_write: assert property ($changed(ack_own_frames) |-> $rose(bvalid))
    else $error("loopback changed without write");
endmodule

bind can_msg_store can_msg_store_monitor #(.RX_DEPTH(RX_DEPTH)) u_mon (.aclk, .aresetn,
  .bvalid, .arb_req, .tx_start, .tx_done, .tx_error, .arb_lost, .tx_pick_valid, .rx_frame_done,
  .rx_frame_ok, .rx_filter_hit, .rx_own_frame, .rx_space, .ack_own_frames, .tx_irq, .rx_irq,
  .overrun_irq);

/* File: can_bus_node.sv */
`timescale 1ns/1ps
module can_bus_node
  import can_msg_store_pkg::*;
(
  // clock
  input wire logic aclk,
  // transmit events
  output logic arb_req,
  output logic tx_start,
  output logic tx_done,
  output logic tx_error,
  output logic arb_lost,
  // receive path
  output logic rx_byte_we,
  output logic [3:0] rx_byte_idx,
  output logic [7:0] rx_byte_data,
  output logic rx_frame_done,
  output logic rx_frame_ok,
  output logic rx_filter_hit,
  output logic rx_own_frame
);
  // ---------------------------------
  // bus events and frames
  // ---------------------------------
  logic [4:0] ev = 5'h0;
  assign {arb_lost, tx_error, tx_done, tx_start, arb_req} = ev;
  initial begin
    {rx_byte_we, rx_byte_idx, rx_byte_data, rx_frame_done, rx_frame_ok, rx_filter_hit} = '0;
    rx_own_frame = 1'b0;
  end
  // one event per call, retry by a fresh arbitration
  task automatic eng(input int k);
    @(posedge aclk);
    ev <= 5'h1 << k;
    @(posedge aclk);
    ev <= 5'h0;
  endtask
  // frames follow each other with one idle cycle after the done cycle
  task automatic frame(input logic [7:0] t, input logic ok, input logic hit, input logic own);
    for (int b = 0; b < RX_MSG_BYTES; b++) begin
      @(posedge aclk);
      {rx_byte_we, rx_byte_idx, rx_byte_data} <= {1'b1, 4'(b), t + 8'(b)};
    end
    @(posedge aclk);
    {rx_byte_we, rx_byte_data} <= {1'b0, ~rx_byte_data};
    {rx_frame_done, rx_frame_ok, rx_filter_hit, rx_own_frame} <= {1'b1, ok, hit, own};
    @(posedge aclk);
    {rx_frame_done, rx_frame_ok, rx_filter_hit, rx_own_frame} <= {1'b0, ~ok, ~hit, ~own};
  endtask
endmodule

/* File: can_msg_store_test.sv */
`timescale 1ns/1ps
module can_msg_store_test
  import can_msg_store_pkg::*;
();
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0] bresp, rresp, rd_resp, wr_resp, tx_pick_idx;
  logic [3:0] wstrb = 4'hf;
  logic [15:0] timestamp = 16'h1234;
  logic arb_req, tx_start, tx_done, tx_error, arb_lost, tx_pick_valid;
  logic [TX_MSG_BYTES*8-1:0] tx_frame;
  logic rx_byte_we, rx_frame_done, rx_frame_ok, rx_filter_hit, rx_own_frame, rx_space;
  logic [3:0] rx_byte_idx;
  logic [7:0] rx_byte_data;
  logic ack_own_frames, tx_irq, rx_irq, overrun_irq;
  logic [31:0] local_priority_field [3] = '{32'h5, 32'h2, 32'h2};
  int fail_count = 0;
  int checks_done = 0;

  can_msg_store u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .arb_req, .tx_start, .tx_done, .tx_error,
    .arb_lost, .tx_pick_valid, .tx_pick_idx, .tx_frame, .rx_byte_we, .rx_byte_idx,
    .rx_byte_data, .rx_frame_done, .rx_frame_ok, .rx_filter_hit, .rx_own_frame, .rx_space,
    .ack_own_frames, .timestamp, .tx_irq, .rx_irq, .overrun_irq);
  can_bus_node u_node (.aclk, .arb_req, .tx_start, .tx_done, .tx_error, .arb_lost,
    .rx_byte_we, .rx_byte_idx, .rx_byte_data, .rx_frame_done, .rx_frame_ok, .rx_filter_hit,
    .rx_own_frame);

  // ---------------------------------
  // bus tasks
  // ---------------------------------
  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    wr_resp = bresp;
    bready <= 1'b0;
    if (n >= 50) chk("write timeout", 32'h1, 32'h0);
    if (n >= 50) end_of_test();
  endtask
  task automatic rd(input string w, input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    {arvalid, rready, araddr} <= {2'h3, a};
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    {rd_data, rd_resp} = {rdata, rresp};
    rready <= 1'b0;
    if (n >= 50) chk("read timeout", 32'h1, 32'h0);
    if (n >= 50) end_of_test();
    chk(w, rd_data, e);
  endtask
  task automatic pick(input logic [1:0] e);
    u_node.eng(0);
    #1;
    chk("pick", {30'h0, tx_pick_idx}, {30'h0, e});
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ---------------------------------
  // scenarios
  // ---------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd("tx_flag", ADDR_TX_FLAG, 32'(TX_EMPTY_RST));
    rd("rx_flag", ADDR_RX_FLAG, 32'h0);
    rd("unmapped", 8'h30, 32'h0);
    chk("rresp", {30'h0, rd_resp}, {30'h0, AXI_SLVERR});
    wr(8'h30, 32'h1);
    chk("bresp", {30'h0, wr_resp}, {30'h0, AXI_SLVERR});
    wr(ADDR_CTRL, 32'h76);
    chk("tx_irq", {31'h0, tx_irq}, 32'h1);
    wstrb <= 4'he;
    wr(ADDR_CTRL, 32'h0);
    wstrb <= 4'hf;
    chk("tx_irq_strb", {31'h0, tx_irq}, 32'h1);
    for (int i = 0; i < TX_BUFS; i++) begin
      wr(ADDR_TX_SEL, 32'h1 << i);
      rd("tx_sel", ADDR_TX_SEL, 32'h1 << i);
      for (int b = 0; b < 14; b++)
        wr(8'h80 + 8'(4 * b), (b == 0) ? 32'ha0 + i : (b == 13) ? local_priority_field[i] : 32'(b));
    end
    wr(ADDR_TX_SEL, 32'h1);
    wr(ADDR_TX_FLAG, 32'h1);
    wr(8'hb4, 32'h0);
    wr(ADDR_TX_FLAG, 32'h6);
    chk("tx_irq", {31'h0, tx_irq}, 32'h0);
    pick(2'h1);
    chk("frame", {24'h0, tx_frame[7:0]}, 32'ha1);
    u_node.eng(1);
    u_node.eng(3);
    pick(2'h1);
    u_node.eng(1);
    u_node.eng(2);
    rd("tx_flag", ADDR_TX_FLAG, 32'h2);
    wr(ADDR_TX_SEL, 32'h2);
    rd("tx_stamp", 8'hb8, {24'h0, timestamp[15:8]});
    pick(2'h2);
    u_node.eng(1);
    wr(ADDR_ABORT_REQ, 32'h4);
    rd("abort_ack", ADDR_ABORT_ACK, 32'h0);
    u_node.eng(2);
    rd("tx_flag", ADDR_TX_FLAG, 32'h6);
    rd("abort_ack", ADDR_ABORT_ACK, 32'h0);
    pick(2'h0);
    u_node.eng(1);
    u_node.eng(4);
    #1;
    chk("pick_valid", {31'h0, tx_pick_valid}, 32'h0);
    wr(ADDR_ABORT_REQ, 32'h1);
    rd("abort_ack", ADDR_ABORT_ACK, 32'h1);
    rd("tx_flag", ADDR_TX_FLAG, 32'h7);
    chk("tx_irq", {31'h0, tx_irq}, 32'h1);
    chk("own_ack", {31'h0, ack_own_frames}, 32'h0);
    u_node.frame(8'h01, 1'b1, 1'b0, 1'b0);
    u_node.frame(8'h02, 1'b0, 1'b1, 1'b0);
    u_node.frame(8'h03, 1'b1, 1'b1, 1'b1);
    rd("rx_flag", ADDR_RX_FLAG, 32'h0);
    for (int k = 1; k < 7; k++)
      u_node.frame(8'(k * 16), 1'b1, 1'b1, 1'b0);
    rd("rx_flag", ADDR_RX_FLAG, 32'h3);
    chk("rx_space", {31'h0, rx_space}, 32'h0);
    chk("irqs", {30'h0, rx_irq, overrun_irq}, 32'h3);
    rd("rx_byte0", 8'h40, 32'h10);
    rd("rx_stamp", 8'h74, 32'h12);
    wr(ADDR_RX_FLAG, 32'h3);
    u_node.frame(8'h70, 1'b1, 1'b1, 1'b0);
    for (int k = 2; k < 7; k++) begin
      rd("rx_byte0", 8'h40, (k < 6) ? 32'(k * 16) : 32'h70);
      wr(ADDR_RX_FLAG, 32'h1);
    end
    rd("rx_flag", ADDR_RX_FLAG, 32'h0);
    wr(ADDR_CTRL, 32'h77);
    chk("own_ack", {31'h0, ack_own_frames}, 32'h1);
    u_node.frame(8'h80, 1'b1, 1'b1, 1'b1);
    rd("rx_byte0", 8'h40, 32'h80);
    end_of_test();
  end
endmodule
